// >>> iptmr_pins.sv
// Far-side model: the 32 kHz oscillator and the circuits hanging on the timer pins.
module iptmr_pins
  import iptmr_pkg::*;
(
  input  wire logic               aclk,
  input  wire logic [NUM_BLK-1:0] pin_a_out,
  input  wire logic [NUM_BLK-1:0] pin_a_oe,
  output logic                    slow_clk,
  output logic [NUM_BLK-1:0]      pin_a_in,
  output logic [NUM_BLK-1:0]      pin_b_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [NUM_BLK-1:0] wobble;
  initial begin
    wobble = 3'h5;
    slow_clk = 1'b0;
    forever #15625 slow_clk = ~slow_clk;
  end
  // A released pin has no pull, so it shows a level that changes every cycle.
  always @(posedge aclk) wobble <= ~wobble;
  assign pin_a_in = (pin_a_oe & pin_a_out) | (~pin_a_oe & wobble);
  assign pin_b_in = ~wobble;
endmodule

// >>> iptmr_pkg.sv
// Constants, register layouts and modes shared by the idle and PWM timer block.
package iptmr_pkg;
  localparam int unsigned NUM_BLK = 3;
  localparam int unsigned CNT_W   = 16;

  // Register byte addresses on the AXI4-Lite bus.
  localparam logic [7:0] ADDR_IDLE_MODE = 8'h00;
  localparam logic [7:0] ADDR_IRQ_CTRL  = 8'h04;
  localparam logic [7:0] ADDR_FAST_CLK  = 8'h08;
  localparam logic [7:0] ADDR_PIN_STAT  = 8'h0c;
  // Timer block n (0..2) sits in the 16-byte page whose upper nibble is n+1.
  localparam logic [3:0] BLK_PAGE_FIRST = 4'h1;
  localparam logic [3:0] BLK_PAGE_LAST  = 4'h3;
  localparam logic [3:0] OFS_CTRL       = 4'h0;
  localparam logic [3:0] OFS_COUNT      = 4'h4;
  localparam logic [3:0] OFS_RELOAD_A   = 4'h8;
  localparam logic [3:0] OFS_RELOAD_B   = 4'hc;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Idle timer tap selection.
  localparam logic [4:0] IDLE_TAP_BASE = 5'h0b;
  localparam logic [2:0] IDLE_SEL_MAX  = 3'h4;

  // Instruction cycle clock is the fast internal clock divided by ten.
  localparam logic [3:0] INSTR_DIV = 4'ha;

  localparam logic [2:0] MODE_PWM_TOGGLE = 3'h5;
  localparam logic [2:0] MODE_PWM_QUIET  = 3'h4;

  typedef struct packed {
    logic       slow_osc_on;
    logic       fast_osc_on;
    logic       dual_clock_enable;
    logic       core_clock_select;
    logic       reserved_zero_bit;
    logic [2:0] period_sel;
  } iptmr_idle_mode_t;

  typedef struct packed {
    logic [1:0] spare_hi;
    logic       idle_irq_pending;
    logic       idle_irq_enable;
    logic [2:0] spare_lo;
    logic       global_irq_enable;
  } iptmr_irq_ctrl_t;

  typedef struct packed {
    logic [5:0] zero;
    logic       block3_fast_clock;
    logic       block2_fast_clock;
  } iptmr_fast_clk_t;

  typedef struct packed {
    logic       irq_enable_b;
    logic       pending_flag_b;
    logic       irq_enable_a;
    logic       pending_flag_a;
    logic [2:0] mode;
    logic       run_control_bit;
  } iptmr_blk_ctrl_t;

  localparam iptmr_idle_mode_t IDLE_MODE_RESET = 8'h00;
  localparam iptmr_irq_ctrl_t  IRQ_CTRL_RESET  = 8'h00;
  localparam iptmr_fast_clk_t  FAST_CLK_RESET  = 8'h00;
  localparam iptmr_blk_ctrl_t  BLK_CTRL_RESET  = 8'h00;
endpackage

// >>> iptmr_top.sv
// Idle timer and three PWM timer blocks behind an AXI4-Lite register slave.
// Contract
// - Idle timer: hidden 16-bit down counter.
// - Idle clock: instruction tick or 32 kHz.
// - Slow modes stop the divide-by-ten stage.
// - Idle underflow taps counter bits 11-15.
// - Underflow sets pending and clears port G6.
// - Idle request needs enable and global enable.
// - Period codes 000-100 double from 4096.
// - Reset clears period select to 4096.
// - Three blocks: counter, two reloads, pins.
// - Block counters and reloads have no reset value.
// - Blocks 2 and 3 may count fast.
// - Fast clock register resets zero, bits 7-2 zero.
// - Three mode bits select operating mode.
// - PWM reloads alternately, A first.
// - PWM optionally toggles pin A on underflow.
// - Alternate pending flags, software clears.
// - Interrupt per reload source when enabled.
// - Modes 101 toggle, 100 no toggle.
// - Run bit starts and stops counter.
module iptmr_top
  import iptmr_pkg::*;
#(
  parameter int unsigned ADDR_W = 8
) (
  input  wire logic               aclk,
  input  wire logic               aresetn,
  input  wire logic [ADDR_W-1:0]  awaddr,
  input  wire logic               awvalid,
  output logic                    awready,
  input  wire logic [31:0]        wdata,
  input  wire logic [3:0]         wstrb,
  input  wire logic               wvalid,
  output logic                    wready,
  output logic [1:0]              bresp,
  output logic                    bvalid,
  input  wire logic               bready,
  input  wire logic [ADDR_W-1:0]  araddr,
  input  wire logic               arvalid,
  output logic                    arready,
  output logic [31:0]             rdata,
  output logic [1:0]              rresp,
  output logic                    rvalid,
  input  wire logic               rready,
  input  wire logic               slow_clk_pin,
  input  wire logic [NUM_BLK-1:0] timer_pin_a_in,
  output logic [NUM_BLK-1:0]      timer_pin_a_out,
  output logic [NUM_BLK-1:0]      timer_pin_a_oe,
  input  wire logic [NUM_BLK-1:0] timer_pin_b_in,
  output logic                    idle_irq_req,
  output logic                    port_g6_clear,
  output logic [NUM_BLK-1:0]      timer_irq_a,
  output logic [NUM_BLK-1:0]      timer_irq_b
);

  // Bus slave state.
  logic              aw_full, w_full;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0]       w_data;
  logic [3:0]        w_strb;
  logic              next_aw_full, next_w_full, next_bvalid, next_rvalid;
  logic              next_awready, next_wready, next_arready;
  logic [ADDR_W-1:0] next_aw_addr;
  logic [31:0]       next_w_data, next_rdata;
  logic [3:0]        next_w_strb;
  logic [1:0]        next_bresp, next_rresp;
  logic              wr_en;

  // Idle timer and clock state.
  iptmr_idle_mode_t idle_mode, next_idle_mode;
  iptmr_irq_ctrl_t  irq_ctrl, next_irq_ctrl;
  iptmr_fast_clk_t  fast_clk, next_fast_clk;
  logic [CNT_W-1:0] idle_cnt, next_idle_cnt;
  logic [3:0]       div_cnt, next_div_cnt;
  logic             instr_tick, next_instr_tick;
  logic             next_idle_irq_req, next_port_g6_clear;
  logic             slow_mode, idle_tick, idle_uf;
  logic [2:0]       sel_eff;
  logic [4:0]       tap_bit;
  logic [16:0]      tap_mask;

  // Synchronisers for pins from outside the clock domain.
  logic             slow_s1, slow_s2, slow_s3;
  logic [NUM_BLK-1:0] pa_s1, pa_s2, pb_s1, pb_s2;
  logic             slow_edge;

  // Timer blocks.
  iptmr_blk_ctrl_t    ctrl [NUM_BLK];
  iptmr_blk_ctrl_t    next_ctrl [NUM_BLK];
  logic [CNT_W-1:0]   cnt [NUM_BLK];
  logic [CNT_W-1:0]   next_cnt [NUM_BLK];
  logic [CNT_W-1:0]   rld_a [NUM_BLK];
  logic [CNT_W-1:0]   next_rld_a [NUM_BLK];
  logic [CNT_W-1:0]   rld_b [NUM_BLK];
  logic [CNT_W-1:0]   next_rld_b [NUM_BLK];
  logic [NUM_BLK-1:0] sel_b, next_sel_b, pin_a, next_pin_a, next_pin_oe;
  logic [NUM_BLK-1:0] next_irq_a, next_irq_b;
  logic [NUM_BLK-1:0] blk_tick, running, uf;

  logic [3:0]  wr_page, wr_ofs;
  logic        wr_blk_hit;
  logic [1:0]  wr_blk;

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
    merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  function automatic logic in_blk_page(input logic [3:0] page);
    in_blk_page = (page >= BLK_PAGE_FIRST) && (page <= BLK_PAGE_LAST);
  endfunction

  // ---------------- AXI4-Lite slave ----------------
  assign wr_en      = aw_full && w_full && !bvalid;
  assign wr_page    = aw_addr[7:4];
  assign wr_ofs     = aw_addr[3:0];
  assign wr_blk_hit = wr_en && in_blk_page(wr_page);
  assign wr_blk     = 2'(wr_page - BLK_PAGE_FIRST);

  always_comb begin
    logic [3:0] rp;
    logic [1:0] rb;
    rp = araddr[7:4];
    rb = 2'(rp - BLK_PAGE_FIRST);
    next_aw_full = aw_full;
    next_aw_addr = aw_addr;
    next_w_full  = w_full;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_bvalid  = bvalid;
    next_bresp   = bresp;
    next_rvalid  = rvalid;
    next_rdata   = rdata;
    next_rresp   = rresp;
    if (awvalid && awready) begin
      next_aw_full = 1'b1;
      next_aw_addr = awaddr;
    end
    if (wvalid && wready) begin
      next_w_full = 1'b1;
      next_w_data = wdata;
      next_w_strb = wstrb;
    end
    if (bvalid && bready) begin
      next_bvalid = 1'b0;
    end
    if (wr_en) begin
      next_aw_full = 1'b0;
      next_w_full  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = ((aw_addr >> 8) == '0 && (aw_addr[7:0] == ADDR_IDLE_MODE ||
                      aw_addr[7:0] == ADDR_IRQ_CTRL || aw_addr[7:0] == ADDR_FAST_CLK ||
                      aw_addr[7:0] == ADDR_PIN_STAT || (in_blk_page(wr_page) && wr_ofs[1:0] == 2'h0)))
                     ? RESP_OKAY : RESP_SLVERR;
    end
    if (rvalid && rready) begin
      next_rvalid = 1'b0;
    end
    if (arvalid && arready) begin
      next_rvalid = 1'b1;
      next_rresp  = RESP_OKAY;
      next_rdata  = 32'h0;
      if ((araddr >> 8) != '0) begin
        next_rresp = RESP_SLVERR;
      end else if (araddr[7:0] == ADDR_IDLE_MODE) begin
        // The hidden idle counter has no address at all.
        next_rdata[7:0] = {idle_mode[7:4], 1'b0, idle_mode.period_sel};
      end else if (araddr[7:0] == ADDR_IRQ_CTRL) begin
        next_rdata[7:0] = irq_ctrl;
      end else if (araddr[7:0] == ADDR_FAST_CLK) begin
        next_rdata[7:0] = fast_clk;
      end else if (araddr[7:0] == ADDR_PIN_STAT) begin
        next_rdata[7:0] = {1'b0, pb_s2, 1'b0, pa_s2};
      end else if (in_blk_page(rp) && araddr[1:0] == 2'h0) begin
        case (araddr[3:0])
          OFS_CTRL:     next_rdata[7:0]  = ctrl[rb];
          OFS_COUNT:    next_rdata[15:0] = cnt[rb];
          OFS_RELOAD_A: next_rdata[15:0] = rld_a[rb];
          OFS_RELOAD_B: next_rdata[15:0] = rld_b[rb];
          default:      next_rresp       = RESP_SLVERR;
        endcase
      end else begin
        next_rresp = RESP_SLVERR;
      end
    end
    next_awready = !next_aw_full;
    next_wready  = !next_w_full;
    next_arready = !next_rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full <= 1'b0;
      aw_addr <= '0;
      w_full  <= 1'b0;
      w_data  <= 32'h0;
      w_strb  <= 4'h0;
      bvalid  <= 1'b0;
      bresp   <= RESP_OKAY;
      rvalid  <= 1'b0;
      rdata   <= 32'h0;
      rresp   <= RESP_OKAY;
      awready <= 1'b0;
      wready  <= 1'b0;
      arready <= 1'b0;
    end else begin
      aw_full <= next_aw_full;
      aw_addr <= next_aw_addr;
      w_full  <= next_w_full;
      w_data  <= next_w_data;
      w_strb  <= next_w_strb;
      bvalid  <= next_bvalid;
      bresp   <= next_bresp;
      rvalid  <= next_rvalid;
      rdata   <= next_rdata;
      rresp   <= next_rresp;
      awready <= next_awready;
      wready  <= next_wready;
      arready <= next_arready;
    end
  end

  // ---------------- Pin synchronisers ----------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {slow_s1, slow_s2, slow_s3} <= 3'h0;
      pa_s1 <= '0;
      pa_s2 <= '0;
      pb_s1 <= '0;
      pb_s2 <= '0;
    end else begin
      slow_s1 <= slow_clk_pin;
      slow_s2 <= slow_s1;
      slow_s3 <= slow_s2;
      pa_s1   <= timer_pin_a_in;
      pa_s2   <= pa_s1;
      pb_s1   <= timer_pin_b_in;
      pb_s2   <= pb_s1;
    end
  end
  assign slow_edge = slow_s2 && !slow_s3;

  // ---------------- Clocking and idle timer ----------------
  assign slow_mode = idle_mode.dual_clock_enable || idle_mode.core_clock_select;
  assign idle_tick = slow_mode ? slow_edge : instr_tick;
  // Reserved codes are undefined; they are held at the longest period.
  assign sel_eff   = (idle_mode.period_sel > IDLE_SEL_MAX) ? IDLE_SEL_MAX : idle_mode.period_sel;
  assign tap_bit   = IDLE_TAP_BASE + 5'(sel_eff);
  assign tap_mask  = 17'((18'h1 << (tap_bit + 5'h1)) - 18'h1);
  // The tap bit underflows when it and every lower bit are zero at a tick.
  assign idle_uf   = idle_tick && ((idle_cnt & tap_mask[15:0]) == 16'h0);

  always_comb begin
    next_div_cnt       = div_cnt;
    next_instr_tick    = 1'b0;
    next_idle_cnt      = idle_cnt;
    next_idle_mode     = idle_mode;
    next_irq_ctrl      = irq_ctrl;
    next_fast_clk      = fast_clk;
    if (slow_mode) begin
      next_div_cnt = 4'h0;
    end else if (div_cnt == INSTR_DIV - 4'h1) begin
      next_div_cnt    = 4'h0;
      next_instr_tick = 1'b1;
    end else begin
      next_div_cnt = div_cnt + 4'h1;
    end
    if (idle_tick) begin
      next_idle_cnt = idle_cnt - 16'h1;
    end
    if (wr_en && w_strb[0] && (aw_addr >> 8) == '0) begin
      case (aw_addr[7:0])
        ADDR_IDLE_MODE: next_idle_mode = {w_data[7:4], 1'b0, w_data[2:0]};
        ADDR_IRQ_CTRL:  next_irq_ctrl  = {2'h0, w_data[5:4], 3'h0, w_data[0]};
        ADDR_FAST_CLK:  next_fast_clk  = {6'h0, w_data[1:0]};
        default:        next_fast_clk  = next_fast_clk;
      endcase
    end
    // A hardware set beats a software clear written in the same cycle.
    if (idle_uf) begin
      next_irq_ctrl.idle_irq_pending = 1'b1;
    end
    next_port_g6_clear = idle_uf;
    next_idle_irq_req  = next_irq_ctrl.idle_irq_pending && next_irq_ctrl.idle_irq_enable &&
                         next_irq_ctrl.global_irq_enable;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_cnt       <= 4'h0;
      instr_tick    <= 1'b0;
      idle_cnt      <= 16'h0;
      idle_mode     <= IDLE_MODE_RESET;
      irq_ctrl      <= IRQ_CTRL_RESET;
      fast_clk      <= FAST_CLK_RESET;
      idle_irq_req  <= 1'b0;
      port_g6_clear <= 1'b0;
    end else begin
      div_cnt       <= next_div_cnt;
      instr_tick    <= next_instr_tick;
      idle_cnt      <= next_idle_cnt;
      idle_mode     <= next_idle_mode;
      irq_ctrl      <= next_irq_ctrl;
      fast_clk      <= next_fast_clk;
      idle_irq_req  <= next_idle_irq_req;
      port_g6_clear <= next_port_g6_clear;
    end
  end

  // ---------------- PWM timer blocks ----------------
  assign blk_tick[0] = instr_tick;
  assign blk_tick[1] = fast_clk.block2_fast_clock ? 1'b1 : instr_tick;
  assign blk_tick[2] = fast_clk.block3_fast_clock ? 1'b1 : instr_tick;

  always_comb begin
    for (int i = 0; i < NUM_BLK; i++) begin
      next_ctrl[i]  = ctrl[i];
      next_cnt[i]   = cnt[i];
      next_rld_a[i] = rld_a[i];
      next_rld_b[i] = rld_b[i];
      next_sel_b[i] = sel_b[i];
      next_pin_a[i] = pin_a[i];
      running[i]    = ctrl[i].run_control_bit &&
                      (ctrl[i].mode == MODE_PWM_TOGGLE || ctrl[i].mode == MODE_PWM_QUIET);
      uf[i]         = blk_tick[i] && running[i] && cnt[i] == 16'h0;
      if (blk_tick[i] && running[i]) begin
        next_cnt[i] = cnt[i] - 16'h1;
      end
      if (!running[i]) begin
        next_sel_b[i] = 1'b0;
      end
      if (wr_blk_hit && 2'(i) == wr_blk) begin
        case (wr_ofs)
          OFS_CTRL:     if (w_strb[0]) next_ctrl[i] = w_data[7:0];
          OFS_COUNT:    next_cnt[i]   = merge16(cnt[i], w_data, w_strb);
          OFS_RELOAD_A: next_rld_a[i] = merge16(rld_a[i], w_data, w_strb);
          OFS_RELOAD_B: next_rld_b[i] = merge16(rld_b[i], w_data, w_strb);
          default:      next_sel_b[i] = next_sel_b[i];
        endcase
      end
      // The reload and its pending flag land on the same edge, and win over the bus.
      if (uf[i]) begin
        next_cnt[i]   = sel_b[i] ? rld_b[i] : rld_a[i];
        next_sel_b[i] = !sel_b[i];
        if (sel_b[i]) begin
          next_ctrl[i].pending_flag_b = 1'b1;
        end else begin
          next_ctrl[i].pending_flag_a = 1'b1;
        end
        if (ctrl[i].mode == MODE_PWM_TOGGLE) begin
          next_pin_a[i] = !pin_a[i];
        end
      end
      next_pin_oe[i] = next_ctrl[i].mode == MODE_PWM_TOGGLE || next_ctrl[i].mode == MODE_PWM_QUIET;
      next_irq_a[i]  = next_ctrl[i].pending_flag_a && next_ctrl[i].irq_enable_a;
      next_irq_b[i]  = next_ctrl[i].pending_flag_b && next_ctrl[i].irq_enable_b;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < NUM_BLK; i++) begin
        ctrl[i] <= BLK_CTRL_RESET;
      end
      sel_b           <= '0;
      pin_a           <= '0;
      timer_pin_a_out <= '0;
      timer_pin_a_oe  <= '0;
      timer_irq_a     <= '0;
      timer_irq_b     <= '0;
    end else begin
      ctrl            <= next_ctrl;
      sel_b           <= next_sel_b;
      pin_a           <= next_pin_a;
      timer_pin_a_out <= next_pin_a;
      timer_pin_a_oe  <= next_pin_oe;
      timer_irq_a     <= next_irq_a;
      timer_irq_b     <= next_irq_b;
    end
  end

  // Counter and reload words power up random, so they take no reset.
  always_ff @(posedge aclk) begin
    cnt   <= next_cnt;
    rld_a <= next_rld_a;
    rld_b <= next_rld_b;
  end

  // ---------------- Assertions ----------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_DIV_STOPPED: assert property (slow_mode |=> ##1 !instr_tick)
    else $error("Instruction tick ran in slow mode.");
  AST_IDLE_SOURCE: assert property (idle_tick && !slow_mode |-> instr_tick)
    else $error("Idle timer ticked off the wrong clock.");
  AST_IDLE_PEND: assert property (idle_uf |=> irq_ctrl.idle_irq_pending && port_g6_clear)
    else $error("Idle underflow did not set pending and clear port G6.");
  AST_IDLE_REQ: assert property (idle_irq_req == (irq_ctrl.idle_irq_pending && irq_ctrl.idle_irq_enable &&
                                 irq_ctrl.global_irq_enable))
    else $error("Idle interrupt request disagrees with its enables.");
  AST_SEL_RESET: assert property (!$past(aresetn) |-> idle_mode.period_sel == 3'h0)
    else $error("Period select not cleared by reset.");
  AST_FAST_ZERO: assert property (fast_clk.zero == 6'h0)
    else $error("Fast clock control upper bits not zero.");
  AST_TAP_PERIOD: assert property (idle_uf && !$past(idle_tick) && sel_eff == 3'h0
                                   |-> idle_cnt[11:0] == 12'h0)
    else $error("Idle underflow off the selected tap.");

  for (genvar g = 0; g < NUM_BLK; g++) begin : g_chk
    AST_RELOAD_A: assert property (uf[g] && !sel_b[g] |=> cnt[g] == $past(rld_a[g]) && ctrl[g].pending_flag_a)
      else $error("Underflow did not reload from register A.");
    AST_RELOAD_B: assert property (uf[g] && sel_b[g] |=> cnt[g] == $past(rld_b[g]) && ctrl[g].pending_flag_b)
      else $error("Underflow did not reload from register B.");
    AST_TOGGLE: assert property (uf[g] && ctrl[g].mode == MODE_PWM_TOGGLE |=> pin_a[g] != $past(pin_a[g]))
      else $error("Pin A did not toggle on underflow.");
    // Case equality, because a counter that was never written still holds its unknown power-up value.
    AST_STOPPED: assert property (!running[g] && !(wr_blk_hit && wr_blk == 2'(g)) |=> cnt[g] === $past(cnt[g]))
      else $error("Stopped timer changed its count.");
  end
  AST_SLOW_BLOCK1: assert property (blk_tick[0] |-> instr_tick)
    else $error("Block 1 counted off the fast clock.");

endmodule

// >>> tb_idle_and_pwm_timers.sv
// Self-checking bench for the idle and PWM timer block.
module tb_idle_and_pwm_timers import iptmr_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, slow_clk, idle_irq_req, port_g6_clear;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, resp;
  logic [NUM_BLK-1:0] pa_in, pa_out, pa_oe, pb_in, irq_a, irq_b;
  int num_errors = 0, comparisons = 0, seed, cyc = 0, n;

  iptmr_top dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .slow_clk_pin(slow_clk), .timer_pin_a_in(pa_in), .timer_pin_a_out(pa_out),
    .timer_pin_a_oe(pa_oe), .timer_pin_b_in(pb_in), .idle_irq_req(idle_irq_req),
    .port_g6_clear(port_g6_clear), .timer_irq_a(irq_a), .timer_irq_b(irq_b));
  iptmr_pins far (.aclk(aclk), .pin_a_out(pa_out), .pin_a_oe(pa_oe), .slow_clk(slow_clk),
    .pin_a_in(pa_in), .pin_b_in(pb_in));

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task automatic report_and_stop;
    if (num_errors == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // The whole run, idle periods included, takes about 82000 cycles, well inside this ceiling.
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 100000) begin
      num_errors++;
      report_and_stop;
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  function automatic int ival(input logic [15:0] r, input int m);
    return (int'(r) + 1) * m;
  endfunction

  // Handshakes are sampled on the falling edge, which sees what the next rising edge will take.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w, b;
    // Every request starts just after a rising edge, even when called after a falling-edge check.
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    b = 1'b0;
    while (!b) begin
      @(negedge aclk);
      aw = awvalid & awready;
      w = wvalid & wready;
      b = bvalid & bready;
      resp = bresp;
      @(posedge aclk);
      if (aw) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
    end
  endtask

  task automatic chkrd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic ar, r;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    r = 1'b0;
    while (!r) begin
      @(negedge aclk);
      ar = arvalid & arready;
      r = rvalid & rready;
      rd = rdata;
      resp = rresp;
      @(posedge aclk);
      if (ar) arvalid <= 1'b0;
    end
    chk($sformatf("rdata at %h", a), e, rd);
    chk("rresp", 32'(er), 32'(resp));
  endtask

  task automatic pwm(input int blk, input int mult, input logic [15:0] ra, input logic [15:0] rb);
    logic [7:0] base;
    logic p;
    base = 8'(16 * (blk + 1));
    wr(base, 32'h0);
    wr(base + 8'h8, 32'(ra));
    wr(base + 8'hc, 32'(rb));
    wr(base + 8'h4, 32'h0);
    p = pa_out[blk];
    wr(base, 32'hab);
    for (int k = 0; k < 4; k++) begin
      n = 0;
      do begin
        @(negedge aclk);
        n++;
      end while (pa_out[blk] === p);
      p = pa_out[blk];
      if (k > 0) chk("toggle gap", 32'(ival(k[0] ? ra : rb, mult)), 32'(n));
      if (k == 0) chk("irq a", 32'h1, 32'(irq_a[blk]));
      if (k == 1) chk("irq b", 32'h1, 32'(irq_b[blk]));
    end
    chk("pin enable", 32'h1, 32'(pa_oe[blk]));
    wr(base, 32'h0);
    @(negedge aclk);
    chk("irq a", 32'h0, 32'(irq_a[blk]));
    p = pa_out[blk];
    wr(base, 32'h29);
    repeat ((int'(ra) + int'(rb) + 4) * mult) @(negedge aclk);
    chk("pin quiet", 32'(p), 32'(pa_out[blk]));
    chk("irq a", 32'h1, 32'(irq_a[blk]));
    wr(base, 32'h0);
  endtask

  initial begin
    aresetn = 1'b0;
    {awvalid, wvalid, arvalid} = 3'h0;
    {bready, rready} = 2'h3;
    wstrb = 4'hf;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    seed = 14708;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    chkrd(ADDR_IDLE_MODE, 32'h0, RESP_OKAY);
    chkrd(ADDR_FAST_CLK, 32'h0, RESP_OKAY);
    chkrd(8'h10, 32'h0, RESP_OKAY);
    chkrd(8'h44, 32'h0, RESP_SLVERR);
    wr(8'h44, 32'h1);
    chk("bresp", 32'(RESP_SLVERR), 32'(resp));
    wr(ADDR_FAST_CLK, 32'hff);
    chkrd(ADDR_FAST_CLK, 32'h3, RESP_OKAY);
    wr(ADDR_IDLE_MODE, 32'h04);
    chkrd(ADDR_IDLE_MODE, 32'h04, RESP_OKAY);
    wr(ADDR_IDLE_MODE, 32'h00);
    pwm(0, 10, 16'($unsigned($random(seed)) % 9 + 1), 16'($unsigned($random(seed)) % 9 + 1));
    pwm(1, 1, 16'h0, 16'($unsigned($random(seed)) % 40 + 1));
    pwm(2, 1, 16'($unsigned($random(seed)) % 40 + 1), 16'h0);
    wr(8'h14, 32'h1234);
    wr(ADDR_IDLE_MODE, 32'h20);
    wr(8'h10, 32'h09);
    repeat (50) @(negedge aclk);
    chkrd(8'h14, 32'h1234, RESP_OKAY);
    wr(8'h10, 32'h0);
    wr(ADDR_IDLE_MODE, 32'h00);
    wr(ADDR_IRQ_CTRL, 32'h11);
    for (int k = 0; k < 2; k++) begin
      n = 0;
      do begin
        @(negedge aclk);
        n++;
      end while (port_g6_clear !== 1'b1);
    end
    chk("idle gap", 32'(4096 * 10), 32'(n));
    chk("idle irq", 32'h1, 32'(idle_irq_req));
    chkrd(ADDR_IRQ_CTRL, 32'h31, RESP_OKAY);
    wr(ADDR_IRQ_CTRL, 32'h10);
    @(negedge aclk);
    chk("idle irq", 32'h0, 32'(idle_irq_req));
    chkrd(ADDR_IRQ_CTRL, 32'h10, RESP_OKAY);
    report_and_stop;
  end
endmodule
